// ---- logic/rbt_defines.vh ----
`ifndef RBT_DEFINES_VH
`define RBT_DEFINES_VH

// ==========================================================
// data path
`define RBT_DATA_W      8
`define RBT_FIFO_DEPTH  16
`define RBT_FIFO_AW     4

// ==========================================================
// register map, byte addresses on the word-aligned bus
`define RBT_ADDR_W      4
`define RBT_OFS_CTRL    4'h0
`define RBT_OFS_STATUS  4'h4
`define RBT_OFS_STORED  4'h8
`define RBT_OFS_FIFO    4'hC

// ==========================================================
// control fields
`define RBT_CTRL_GATE_N     0
`define RBT_CTRL_DIR        1
`define RBT_CTRL_SEL_12     2
`define RBT_CTRL_SEL_21     3
`define RBT_CTRL_W          4
`define RBT_CTRL_RESET      4'hF

// ==========================================================
// status fields
`define RBT_STAT_ONE_OE     0
`define RBT_STAT_TWO_OE     1
`define RBT_STAT_FIFO_VLD   2
`define RBT_STAT_FIFO_RDY   3

// ==========================================================
// fsm codes
`define RBT_ST_IDLE   2'b01
`define RBT_ST_RESP   2'b10

`endif

// ---- logic/rbt_fifo.v ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// synchronous fifo with valid/ready on both sides
module rbt_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             resetn,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;

  // honest full and empty
  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage, no reset needed
  always @(posedge clk_sys)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data;
  end

  // pointers and fill level
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push & ~pop)
        count_reg <= count_reg + 1'b1;
      else if (pop & ~push)
        count_reg <= count_reg - 1'b1;
    end
  end

endmodule

`default_nettype wire

// ---- logic/rbt_transceiver.v ----
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rbt_defines.vh"

module rbt_transceiver #(
  parameter DATA_W      = `RBT_DATA_W,
  parameter FIFO_DEPTH  = `RBT_FIFO_DEPTH,
  parameter FIFO_AW     = `RBT_FIFO_AW,
  parameter INVERT_12   = 0
) (
  // clock and reset
  input  wire              clk_sys,
  input  wire              resetn,
  // avalon-mm slave
  input  wire [3:0]        avs_address,
  input  wire              avs_read,
  input  wire              avs_write,
  input  wire [31:0]       avs_writedata,
  input  wire [3:0]        avs_byteenable,
  output reg  [31:0]       avs_readdata,
  output wire              avs_waitrequest,
  output reg               avs_readdatavalid,
  // capture clocks, sampled as enables on clk_sys
  input  wire              side_one_capture_clock,
  input  wire              side_two_capture_clock,
  // side one bus pins
  input  wire [DATA_W-1:0] side_one_bus_in,
  output reg  [DATA_W-1:0] side_one_bus_out,
  output reg               side_one_bus_oe,
  // side two bus pins
  input  wire [DATA_W-1:0] side_two_bus_in,
  output reg  [DATA_W-1:0] side_two_bus_out,
  output reg               side_two_bus_oe
);

  // ==========================================================
  // control register and pin steering
  reg  [`RBT_CTRL_W-1:0] ctrl_reg;
  wire                   gate_n;
  wire                   dir;
  wire                   one_to_two_source_select;
  wire                   two_to_one_source_select;

  assign gate_n                   = ctrl_reg[`RBT_CTRL_GATE_N];
  assign dir                      = ctrl_reg[`RBT_CTRL_DIR];
  assign one_to_two_source_select = ctrl_reg[`RBT_CTRL_SEL_12];
  assign two_to_one_source_select = ctrl_reg[`RBT_CTRL_SEL_21];

  // ==========================================================
  // capture edge detection on clk_sys
  reg              cap_one_d_reg;
  reg              cap_two_d_reg;
  wire             cap_one_rise;
  wire             cap_two_rise;
  reg [DATA_W-1:0] store_one_reg;
  reg [DATA_W-1:0] store_two_reg;

  assign cap_one_rise = side_one_capture_clock & ~cap_one_d_reg;
  assign cap_two_rise = side_two_capture_clock & ~cap_two_d_reg;

  // previous capture clock levels
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      cap_one_d_reg <= 1'b1;
      cap_two_d_reg <= 1'b1;
    end
    else
    begin
      cap_one_d_reg <= side_one_capture_clock;
      cap_two_d_reg <= side_two_capture_clock;
    end
  end

  // storage registers, loaded regardless of gate or dir, no reset
  always @(posedge clk_sys)
  begin
    if (cap_one_rise)
      store_one_reg <= side_one_bus_in;
    if (cap_two_rise)
      store_two_reg <= side_two_bus_in;
  end

  // ==========================================================
  // output multiplexers, registered data and enables
  wire [DATA_W-1:0] src_12;
  wire [DATA_W-1:0] src_21;
  wire [DATA_W-1:0] inv_mask;

  assign inv_mask = (INVERT_12 != 0) ? {DATA_W{1'b1}} : {DATA_W{1'b0}};
  assign src_12   = (one_to_two_source_select ? store_one_reg
                    : side_one_bus_in) ^ inv_mask;
  assign src_21   = two_to_one_source_select ? store_two_reg
                    : side_two_bus_in;

  // drive steering
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      side_one_bus_oe  <= 1'b0;
      side_two_bus_oe  <= 1'b0;
      side_one_bus_out <= {DATA_W{1'b0}};
      side_two_bus_out <= {DATA_W{1'b0}};
    end
    else
    begin
      side_one_bus_oe  <= ~gate_n & ~dir;
      side_two_bus_oe  <= ~gate_n & dir;
      side_one_bus_out <= src_21;
      side_two_bus_out <= src_12;
    end
  end

  // ==========================================================
  // fifo of side one captures, drained by software reads
  wire              fifo_in_ready;
  wire              fifo_out_valid;
  wire              fifo_pop;
  wire [DATA_W-1:0] fifo_out_data;
  reg               cap_one_q_reg;

  // stage capture one cycle so the fifo sees the stored byte
  always @(posedge clk_sys)
  begin
    if (!resetn)
      cap_one_q_reg <= 1'b0;
    else
      cap_one_q_reg <= cap_one_rise;
  end

  rbt_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .in_valid  (cap_one_q_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (store_one_reg),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // ==========================================================
  // avalon-mm slave, one wait cycle per access
  localparam ST_IDLE = `RBT_ST_IDLE;
  localparam ST_RESP = `RBT_ST_RESP;

  reg [1:0]  state_reg;
  reg [1:0]  state_next;
  reg [31:0] rd_mux;
  wire       access;
  wire       done;

  assign access          = avs_read | avs_write;
  assign done            = (state_reg == ST_RESP);
  assign avs_waitrequest = access & ~done;
  // pop only what the held read word reported as valid
  assign fifo_pop        = done & avs_read &
                           (avs_address == `RBT_OFS_FIFO) & fifo_out_valid &
                           avs_readdata[31];

  // next state
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (access) state_next = ST_RESP;
      ST_RESP: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // read data mux, unmapped reads return zero
  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      `RBT_OFS_CTRL:   rd_mux[`RBT_CTRL_W-1:0] = ctrl_reg;
      `RBT_OFS_STATUS:
      begin
        rd_mux[`RBT_STAT_ONE_OE]   = side_one_bus_oe;
        rd_mux[`RBT_STAT_TWO_OE]   = side_two_bus_oe;
        rd_mux[`RBT_STAT_FIFO_VLD] = fifo_out_valid;
        rd_mux[`RBT_STAT_FIFO_RDY] = fifo_in_ready;
      end
      `RBT_OFS_STORED:
      begin
        rd_mux[DATA_W-1:0]        = store_one_reg;
        rd_mux[2*DATA_W-1:DATA_W] = store_two_reg;
      end
      `RBT_OFS_FIFO:
      begin
        rd_mux[DATA_W-1:0] = fifo_out_data;
        rd_mux[31]         = fifo_out_valid;
      end
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  // state, control writes, read data
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      state_reg         <= ST_IDLE;
      ctrl_reg          <= `RBT_CTRL_RESET;
      avs_readdata      <= 32'h0000_0000;
      avs_readdatavalid <= 1'b0;
    end
    else
    begin
      state_reg         <= state_next;
      avs_readdatavalid <= done & avs_read;
      // loaded when the read is taken, so it stands as waitrequest drops
      if ((state_reg == ST_IDLE) & avs_read)
        avs_readdata <= rd_mux;
      if (done & avs_write & (avs_address == `RBT_OFS_CTRL) &
          avs_byteenable[0])
        ctrl_reg <= avs_writedata[`RBT_CTRL_W-1:0];
    end
  end

endmodule

`default_nettype wire

// ---- tb/rbt_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// far side agents, they let go while the device drives
module rbt_bus_model (
  // agent data
  input  wire logic [7:0] ag1,
  input  wire logic [7:0] ag2,
  // device pins
  input  wire logic [7:0] out1,
  input  wire logic       oe1,
  input  wire logic [7:0] out2,
  input  wire logic       oe2,
  // resolved wire levels
  output wire logic [7:0] in1,
  output wire logic [7:0] in2
);
  // wire level from whoever drives
  assign in1 = oe1 ? out1 : ag1;
  assign in2 = oe2 ? out2 : ag2;
endmodule
`default_nettype wire

// ---- tb/rbt_transceiver_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checks of the transceiver
module rbt_transceiver_sva #(
  parameter INVERT_12 = 0
) (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       resetn,
  // register bus
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic       avs_readdatavalid,
  // capture clocks
  input wire logic       side_one_capture_clock,
  input wire logic       side_two_capture_clock,
  // bus pins
  input wire logic [7:0] side_one_bus_in,
  input wire logic [7:0] side_one_bus_out,
  input wire logic       side_one_bus_oe,
  input wire logic [7:0] side_two_bus_in,
  input wire logic [7:0] side_two_bus_out,
  input wire logic       side_two_bus_oe
);
  localparam logic [7:0] MSK = INVERT_12 ? 8'hFF : 8'h00;
  logic [7:0] st1_reg, st2_reg;
  logic       c1_reg, c2_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // shadow of the storage registers
  always_ff @(posedge clk_sys)
  begin
    c1_reg <= side_one_capture_clock;
    c2_reg <= side_two_capture_clock;
    if (side_one_capture_clock && !c1_reg)
      st1_reg <= side_one_bus_in;
    if (side_two_capture_clock && !c2_reg)
      st2_reg <= side_two_bus_in;
  end
  // ==========================================================
  // assertions
  a_oe_exclusive: assert property (
    !(side_one_bus_oe && side_two_bus_oe)) else $error("both driven");
  a_one_source: assert property (side_one_bus_oe |->
    side_one_bus_out == $past(side_two_bus_in) ||
    side_one_bus_out == $past(st2_reg)) else $error("bad side one data");
  a_two_source: assert property (side_two_bus_oe |->
    side_two_bus_out == ($past(side_one_bus_in) ^ MSK) ||
    side_two_bus_out == ($past(st1_reg) ^ MSK)) else $error("bad two data");
  a_reset_quiet: assert property (disable iff (1'b0) !resetn |=>
    !side_one_bus_oe && !side_two_bus_oe) else $error("drive in reset");
  a_wait_first: assert property ($rose(avs_read) || $rose(avs_write)
    |-> avs_waitrequest) else $error("no wait cycle");
  a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("wait too long");
  a_rdv_follows: assert property (avs_read && !avs_waitrequest
    |=> avs_readdatavalid) else $error("read data missing");
  a_rdv_pulse: assert property (avs_readdatavalid |=> !avs_readdatavalid)
    else $error("valid too long");
endmodule
bind rbt_transceiver rbt_transceiver_sva #(.INVERT_12(INVERT_12)) u_sva (
  .clk_sys, .resetn, .avs_read, .avs_write, .avs_waitrequest,
  .avs_readdatavalid, .side_one_capture_clock, .side_two_capture_clock,
  .side_one_bus_in, .side_one_bus_out, .side_one_bus_oe,
  .side_two_bus_in, .side_two_bus_out, .side_two_bus_oe);
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// self-checking bench
module tb;
  localparam logic [7:0] MSK = 8'hFF;
  logic        clk_sys, resetn, avs_read, avs_write;
  logic        avs_waitrequest, avs_readdatavalid, cap1, cap2, oe1, oe2;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0]  ag1, ag2, in1, in2, out1, out2, s1, s2, out2t;
  logic [7:0]  fq[$];
  int          n_fail, samples_checked, cyc, m;
  rbt_transceiver #(.INVERT_12(1)) DUT (.clk_sys, .resetn, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .avs_readdatavalid, .side_one_capture_clock(cap1),
    .side_two_capture_clock(cap2), .side_one_bus_in(in1),
    .side_one_bus_out(out1), .side_one_bus_oe(oe1), .side_two_bus_in(in2),
    .side_two_bus_out(out2), .side_two_bus_oe(oe2));
  // true build beside the inverting one, listening to the same wires
  rbt_transceiver #(.INVERT_12(0)) dut_true (.clk_sys, .resetn, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata(),
    .avs_waitrequest(), .avs_readdatavalid(), .side_one_capture_clock(cap1),
    .side_two_capture_clock(cap2), .side_one_bus_in(in1),
    .side_one_bus_out(), .side_one_bus_oe(), .side_two_bus_in(in2),
    .side_two_bus_out(out2t), .side_two_bus_oe());
  rbt_bus_model u_bus (.ag1, .ag2, .out1, .oe1, .out2, .oe2, .in1, .in2);
  // clock
  initial
  begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  // watchdog
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
      stop_test(1);
  end
  // ==========================================================
  // tasks
  task stop_test(input bit to);
  begin
    n_fail = n_fail + to;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
  begin
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  end
  endtask
  // one bus cycle, held until wait drops
  task bus(input bit w, input logic [3:0] a, input logic [31:0] d);
  begin
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk_sys);
    while (avs_waitrequest) @(posedge clk_sys);
    q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
  end
  endtask
  // capture pulse, side one also queued for the fifo while the queue holds fewer than 16
  task cap(input bit s);
  begin
    @(posedge clk_sys);
    if (s)
      cap2 <= 1;
    else
      cap1 <= 1;
    if (!s && fq.size() < 16)
      fq.push_back(ag1);
    @(posedge clk_sys);
    cap1 <= 0;
    cap2 <= 0;
    @(posedge clk_sys);
  end
  endtask
  function logic [7:0] pick(input logic s, input logic [7:0] l, st);
    return s ? st : l;
  endfunction
  // ==========================================================
  // main sequence
  initial
  begin
    {resetn, avs_read, avs_write, cap1, cap2, avs_address} = 0;
    {avs_writedata, ag1, ag2, n_fail, samples_checked, cyc} = 0;
    avs_byteenable = 4'hF;
    s1 = 8'($urandom(3));
    repeat (12) @(posedge clk_sys);
    resetn <= 1;
    bus(0, 4'h0, 0);
    chk("ctrl", 32'hF, q);
    bus(1, 4'h4, 32'h3);
    bus(0, 4'h4, 0);
    chk("status", 32'h8, q);
    bus(0, 4'h2, 0);
    chk("unmapped", 0, q);
    $display("test reset done");
    ag1 <= 8'($urandom);
    ag2 <= 8'($urandom);
    cap(0);
    cap(1);
    s1 = ag1;
    s2 = ag2;
    bus(0, 4'h8, 0);
    chk("stored", {16'h0, s2, s1}, q);
    $display("test capture done");
    for (m = 0; m < 4; m++)
    begin
      @(posedge clk_sys);
      ag1 <= 8'($urandom);
      ag2 <= 8'($urandom);
      bus(1, 4'h0, {28'h0, m[1], m[1], m[0], 1'b0});
      repeat (3) @(negedge clk_sys);
      chk("oe1", !m[0], oe1);
      chk("oe2", m[0], oe2);
      if (m[0])
      begin
        chk("out2", pick(m[1], ag1, s1) ^ MSK, out2);
        chk("out2t", pick(m[1], ag1, s1), out2t);
      end
      else
        chk("out1", pick(m[1], ag2, s2), out1);
    end
    ag1 <= 8'($urandom);
    cap(0);
    @(negedge clk_sys);
    chk("restore", ag1 ^ MSK, out2);
    chk("restore_t", ag1, out2t);
    bus(1, 4'h0, 32'hF);
    repeat (2) @(negedge clk_sys);
    chk("isolate", 0, {oe1, oe2});
    $display("test modes done");
    for (m = 0; m < 19; m++)
    begin
      ag1 <= 8'($urandom);
      cap(0);
    end
    bus(0, 4'h4, 0);
    chk("full", 32'h4, q);
    while (fq.size() > 0)
    begin
      bus(0, 4'hC, 0);
      chk("pop", {1'b1, 23'h0, fq.pop_front()}, q);
    end
    bus(0, 4'hC, 0);
    chk("empty", 0, q[31]);
    $display("test fifo done");
    stop_test(0);
  end
endmodule
`default_nettype wire
